/* design/rtsc_consts.vh */
// Constants for the recorder trigger source combiner.
// Assumes inclusion by bare name from design files only.
`ifndef RTSC_CONSTS_VH
`define RTSC_CONSTS_VH

// Clock and timing
`define RTSC_CLK_NS          50
`define RTSC_FILT_CHART_MS   10
`define RTSC_NS_PER_MS       1000000

// APB byte offsets
`define RTSC_OFS_CTRL        8'h00
`define RTSC_OFS_LEVEL       8'h04
`define RTSC_OFS_PATTERN     8'h08
`define RTSC_OFS_FILT        8'h0C
`define RTSC_OFS_TENTH       8'h10
`define RTSC_OFS_START       8'h14
`define RTSC_OFS_END         8'h18
`define RTSC_OFS_INTERVAL    8'h1C
`define RTSC_OFS_STATUS      8'h20

// CTRL field positions
`define RTSC_CTRL_AND        0
`define RTSC_CTRL_RMS_EN     1
`define RTSC_CTRL_RMS_FALL   2
`define RTSC_CTRL_MAINS_LO   3
`define RTSC_CTRL_RMS_CH_LO  5
`define RTSC_CTRL_LOP_LO     7
`define RTSC_CTRL_EXT_EN     9
`define RTSC_CTRL_TMR_EN     10
`define RTSC_CTRL_SINGLE     11
`define RTSC_CTRL_FUNC_LO    12
`define RTSC_CTRL_FILT_EN    14
`define RTSC_CTRL_W          15
`define RTSC_CTRL_RST        15'h0000

// Encodings
`define RTSC_LOP_OFF         2'h0
`define RTSC_LOP_AND         2'h1
`define RTSC_LOP_OR          2'h2
`define RTSC_PAT_LOW         2'h1
`define RTSC_PAT_HIGH        2'h2
`define RTSC_FUNC_CAPTURE    2'h0
`define RTSC_FUNC_SPECTRUM   2'h1
`define RTSC_FUNC_CHART      2'h2
`define RTSC_FUNC_RMSCHART   2'h3
`define RTSC_MAINS_50        2'h0
`define RTSC_MAINS_60        2'h1
`define RTSC_MAINS_DC        2'h2

// Filter width limits in tenths of a division
`define RTSC_FILT_MIN        7'h01
`define RTSC_FILT_MAX        7'h64

`endif

/* design/rtsc_top.v */
// Trigger decision logic: rms level, logic pattern, outside trigger
// and calendar timer sources joined by AND or OR into one pulse.
// Assumes rms values, rtc seconds and recorder status on CLK_I; logic
// and outside trigger pins are asynchronous. APB slave for settings.
//
// Operation
// - Rms trigger fires on crossing in slope direction
// - Rms supports 50 Hz, 60 Hz or DC
// - Switching to AND turns logic trigger off
// - Under AND rms true at start if beyond
// - Logic AND needs every channel matching
// - Logic OR needs one match; off setting
// - Pattern per channel: ignore, low, high
// - Filter needs condition held full width
// - Capture/spectrum filter off or 0.1-10.0 div
// - Chart functions filter off or 10 ms
// - Logic condition true at start waits
// - Outside trigger on ground short or fall
// - Outside trigger has enable setting
// - Timer fires every interval start to end
// - Single mode timer-only fires once at start
// - Triggers ignored during post-processing
// - OR links all sources independently
// - AND timer arms at start and intervals
// - AND zero interval arms whole window
// - Interval ticks during recording discarded
// - End time stops charts now, capture later
`timescale 1ns/100ps
`include "rtsc_consts.vh"

module rtsc_top #(
    parameter FILT_CHART_CYC = `RTSC_FILT_CHART_MS * `RTSC_NS_PER_MS
                               / `RTSC_CLK_NS
) (
    // Clock and reset
    input  wire        CLK_I,
    input  wire        SYS_RST_I,
    // APB slave
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [7:0]  PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output wire        PREADY_O,
    output wire        PSLVERR_O,
    // Measurement side
    input  wire [15:0] RMS_VALUE_I,
    output reg  [1:0]  RMS_CH_O,
    output reg  [1:0]  MAINS_SEL_O,
    input  wire [3:0]  LOGIC_I,
    input  wire        OUTSIDE_TRIGGER_INPUT_N_I,
    input  wire [31:0] RTC_SEC_I,
    // Recorder status
    input  wire        MEAS_START_I,
    input  wire        STANDBY_I,
    input  wire        RECORDING_I,
    input  wire        POSTPROC_I,
    // Results
    output reg         TRIG_O,
    output reg         ACQ_STOP_O
);

    function [1:0] fld2;
        input [`RTSC_CTRL_W-1:0] w;
        input integer lo;
        begin
            fld2 = w[lo +: 2];
        end
    endfunction

    // Settings
    reg  [`RTSC_CTRL_W-1:0] ctrl_ff;
    reg  [15:0]  level_ff;
    reg  [7:0]   pattern_ff;
    reg  [6:0]   filt_ff;
    reg  [23:0]  tenth_ff;
    reg  [31:0]  start_ff;
    reg  [31:0]  end_ff;
    reg  [31:0]  interval_ff;

    wire       link_and = ctrl_ff[`RTSC_CTRL_AND];
    wire       rms_en   = ctrl_ff[`RTSC_CTRL_RMS_EN];
    wire       rms_fall = ctrl_ff[`RTSC_CTRL_RMS_FALL];
    wire [1:0] lop      = ctrl_ff[`RTSC_CTRL_LOP_LO +: 2];
    wire       ext_en   = ctrl_ff[`RTSC_CTRL_EXT_EN];
    wire       tmr_en   = ctrl_ff[`RTSC_CTRL_TMR_EN];
    wire       single   = ctrl_ff[`RTSC_CTRL_SINGLE];
    wire [1:0] func     = ctrl_ff[`RTSC_CTRL_FUNC_LO +: 2];
    wire       filt_en  = ctrl_ff[`RTSC_CTRL_FILT_EN];
    wire       logic_en = (lop == `RTSC_LOP_AND) || (lop == `RTSC_LOP_OR);
    wire       chart    = (func == `RTSC_FUNC_CHART) ||
                          (func == `RTSC_FUNC_RMSCHART);

    // APB access
    wire wr_en = PSEL_I & PENABLE_I & PWRITE_I;
    wire known = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= `RTSC_OFS_STATUS);
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~known;

    reg  [`RTSC_CTRL_W-1:0] nxt_ctrl;
    reg  [6:0]   nxt_filt;
    wire [31:0]  status;

    always @*
    begin
        nxt_ctrl = PWDATA_I[`RTSC_CTRL_W-1:0];
        // Leaving OR for AND drops the logic source
        if (nxt_ctrl[`RTSC_CTRL_AND] && !link_and)
            nxt_ctrl[`RTSC_CTRL_LOP_LO +: 2] = `RTSC_LOP_OFF;
        // AND may never hold rms and logic together
        if (nxt_ctrl[`RTSC_CTRL_AND] && nxt_ctrl[`RTSC_CTRL_RMS_EN])
            nxt_ctrl[`RTSC_CTRL_LOP_LO +: 2] = `RTSC_LOP_OFF;
        nxt_filt = PWDATA_I[6:0];
        // Clamp on the whole word so large values cannot wrap
        if (PWDATA_I < {25'h0000000, `RTSC_FILT_MIN})
            nxt_filt = `RTSC_FILT_MIN;
        else if (PWDATA_I > {25'h0000000, `RTSC_FILT_MAX})
            nxt_filt = `RTSC_FILT_MAX;
    end

    always @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            ctrl_ff     <= `RTSC_CTRL_RST;
            level_ff    <= 16'h0000;
            pattern_ff  <= 8'h00;
            filt_ff     <= `RTSC_FILT_MIN;
            tenth_ff    <= 24'h000001;
            start_ff    <= 32'h00000000;
            end_ff      <= 32'h00000000;
            interval_ff <= 32'h00000000;
        end
        else if (wr_en)
        begin
            case (PADDR_I)
                `RTSC_OFS_CTRL:     ctrl_ff     <= nxt_ctrl;
                `RTSC_OFS_LEVEL:    level_ff    <= PWDATA_I[15:0];
                `RTSC_OFS_PATTERN:  pattern_ff  <= PWDATA_I[7:0];
                `RTSC_OFS_FILT:     filt_ff     <= nxt_filt;
                `RTSC_OFS_TENTH:    tenth_ff    <= PWDATA_I[23:0];
                `RTSC_OFS_START:    start_ff    <= PWDATA_I;
                `RTSC_OFS_END:      end_ff      <= PWDATA_I;
                `RTSC_OFS_INTERVAL: interval_ff <= PWDATA_I;
                default:            ctrl_ff     <= ctrl_ff;
            endcase
        end
    end

    always @*
    begin
        case (PADDR_I)
            `RTSC_OFS_CTRL:     PRDATA_O = {17'h00000, ctrl_ff};
            `RTSC_OFS_LEVEL:    PRDATA_O = {16'h0000, level_ff};
            `RTSC_OFS_PATTERN:  PRDATA_O = {24'h000000, pattern_ff};
            `RTSC_OFS_FILT:     PRDATA_O = {25'h0000000, filt_ff};
            `RTSC_OFS_TENTH:    PRDATA_O = {8'h00, tenth_ff};
            `RTSC_OFS_START:    PRDATA_O = start_ff;
            `RTSC_OFS_END:      PRDATA_O = end_ff;
            `RTSC_OFS_INTERVAL: PRDATA_O = interval_ff;
            `RTSC_OFS_STATUS:   PRDATA_O = status;
            default:            PRDATA_O = 32'h00000000;
        endcase
    end

    // Rms computer steering
    always @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            RMS_CH_O    <= 2'h0;
            MAINS_SEL_O <= `RTSC_MAINS_50;
        end
        else
        begin
            RMS_CH_O    <= fld2(ctrl_ff, `RTSC_CTRL_RMS_CH_LO);
            MAINS_SEL_O <= fld2(ctrl_ff, `RTSC_CTRL_MAINS_LO);
        end
    end

    // Rms level source
    reg  above_ff;
    reg  above_vld_ff;
    wire above     = (RMS_VALUE_I >= level_ff);
    wire rms_event = rms_en & above_vld_ff &
                     (rms_fall ? (above_ff & ~above)
                               : (~above_ff & above));
    wire rms_level = rms_en & (rms_fall ? ~above : above);

    always @(posedge CLK_I)
    begin
        if (SYS_RST_I || MEAS_START_I)
        begin
            above_ff     <= 1'b0;
            above_vld_ff <= 1'b0;
        end
        else
        begin
            above_ff     <= above;
            above_vld_ff <= 1'b1;
        end
    end

    // Pin synchronisers, three stages
    reg  [4:0] sy1_ff;
    reg  [4:0] sy2_ff;
    reg  [4:0] sy3_ff;
    reg  [4:0] pin_ff;
    wire [4:0] pins = {OUTSIDE_TRIGGER_INPUT_N_I, LOGIC_I};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_sync
            always @(posedge CLK_I)
            begin
                if (SYS_RST_I)
                begin
                    sy1_ff[gi] <= 1'b1;
                    sy2_ff[gi] <= 1'b1;
                    sy3_ff[gi] <= 1'b1;
                    pin_ff[gi] <= 1'b1;
                end
                else
                begin
                    sy1_ff[gi] <= pins[gi];
                    sy2_ff[gi] <= sy1_ff[gi];
                    sy3_ff[gi] <= sy2_ff[gi];
                    if (sy2_ff[gi] == sy3_ff[gi])
                        pin_ff[gi] <= sy3_ff[gi];
                end
            end
        end
    endgenerate

    // Logic pattern source
    wire [3:0] care;
    wire [3:0] hit;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_pat
            assign care[gi] = (pattern_ff[2*gi +: 2] == `RTSC_PAT_LOW) ||
                              (pattern_ff[2*gi +: 2] == `RTSC_PAT_HIGH);
            assign hit[gi]  = (pattern_ff[2*gi +: 2] == `RTSC_PAT_HIGH) ?
                              pin_ff[gi] : ~pin_ff[gi];
        end
    endgenerate

    wire pat_and  = &(~care | hit) & (|care);
    wire pat_or   = |(care & hit);
    wire pat_cond = (lop == `RTSC_LOP_AND) ? pat_and :
                    (lop == `RTSC_LOP_OR)  ? pat_or : 1'b0;

    wire [30:0] width_cap = filt_ff * tenth_ff;
    wire [31:0] width = !filt_en ? 32'h00000000 :
                        chart ? FILT_CHART_CYC[31:0] :
                        {1'b0, width_cap};
    reg  [31:0] held_ff;
    reg         qual_ff;
    reg         qual_prev_ff;
    reg         seen_false_ff;
    wire        logic_event = logic_en & qual_ff & ~qual_prev_ff &
                              seen_false_ff;
    wire        logic_level = logic_en & qual_ff & seen_false_ff;

    always @(posedge CLK_I)
    begin
        if (SYS_RST_I || !pat_cond)
        begin
            held_ff <= 32'h00000000;
            qual_ff <= 1'b0;
        end
        else
        begin
            if (held_ff < width)
                held_ff <= held_ff + 32'h00000001;
            qual_ff <= (held_ff >= width);
        end
    end

    always @(posedge CLK_I)
    begin
        if (SYS_RST_I || MEAS_START_I)
        begin
            qual_prev_ff  <= 1'b0;
            seen_false_ff <= 1'b0;
        end
        else
        begin
            qual_prev_ff <= qual_ff;
            if (!qual_ff)
                seen_false_ff <= 1'b1;
        end
    end

    // Outside trigger source, active low
    reg  ext_prev_ff;
    wire ext_event = ext_en & ext_prev_ff & ~pin_ff[4];
    wire ext_level = ext_en & ~pin_ff[4];

    always @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            ext_prev_ff <= 1'b1;
        else
            ext_prev_ff <= pin_ff[4];
    end

    // Calendar timer source
    reg  [31:0] next_ff;
    reg         tmr_run_ff;
    reg         armed_ff;
    reg         stop_wait_ff;
    wire        others    = rms_en | logic_en | ext_en;
    wire        only_tmr  = tmr_en & ~others;
    wire        tick      = tmr_en & tmr_run_ff &
                            (RTC_SEC_I >= next_ff);
    wire        end_hit   = tmr_en & tmr_run_ff &
                            (RTC_SEC_I >= end_ff) &
                            ~(single & only_tmr);
    wire        in_window = tmr_run_ff & (RTC_SEC_I >= start_ff);
    wire        zero_int  = (interval_ff == 32'h00000000);
    reg         fired_ff;
    wire        take;

    always @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            next_ff    <= 32'h00000000;
            tmr_run_ff <= 1'b0;
        end
        else if (MEAS_START_I)
        begin
            next_ff    <= start_ff;
            tmr_run_ff <= tmr_en;
        end
        else if (end_hit)
            tmr_run_ff <= 1'b0;
        else if (tick)
        begin
            if (single & only_tmr)
                tmr_run_ff <= 1'b0;
            else if (link_and & zero_int)
                next_ff <= end_ff;
            else
                next_ff <= next_ff + interval_ff;
        end
    end

    // Standby arming under AND with timer
    always @(posedge CLK_I)
    begin
        if (SYS_RST_I || MEAS_START_I || end_hit)
            armed_ff <= 1'b0;
        else if (tick && !RECORDING_I)
            armed_ff <= 1'b1;
        else if (take)
            armed_ff <= 1'b0;
    end

    // Combining
    wire and_conds = (~rms_en   | rms_level) &
                     (~logic_en | logic_level) &
                     (~ext_en   | ext_level);
    wire and_gate  = ~tmr_en ? others :
                     (zero_int ? in_window : armed_ff);
    wire and_cond  = and_gate & and_conds;
    wire or_cond   = rms_event | logic_event | ext_event |
                     (tick & ~RECORDING_I);
    wire cond      = link_and ? and_cond : or_cond;
    assign take    = cond & STANDBY_I & ~POSTPROC_I &
                     ~fired_ff;

    always @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            TRIG_O   <= 1'b0;
            fired_ff <= 1'b0;
        end
        else
        begin
            TRIG_O   <= take;
            if (!STANDBY_I)
                fired_ff <= 1'b0;
            else if (take)
                fired_ff <= 1'b1;
        end
    end

    // End of timed measurement
    always @(posedge CLK_I)
    begin
        if (SYS_RST_I || MEAS_START_I)
        begin
            ACQ_STOP_O   <= 1'b0;
            stop_wait_ff <= 1'b0;
        end
        else if (end_hit && (chart || !RECORDING_I))
        begin
            ACQ_STOP_O   <= 1'b1;
            stop_wait_ff <= 1'b0;
        end
        else if (end_hit)
        begin
            ACQ_STOP_O   <= 1'b0;
            stop_wait_ff <= 1'b1;
        end
        else
        begin
            ACQ_STOP_O   <= stop_wait_ff & ~RECORDING_I;
            if (!RECORDING_I)
                stop_wait_ff <= 1'b0;
        end
    end

    assign status = {24'h000000, stop_wait_ff, fired_ff, armed_ff,
                     tmr_run_ff, seen_false_ff, qual_ff, ext_level,
                     above_ff};

endmodule // rtsc_top

/* testbench/rtsc_assertions.sv */
// Port checks for the trigger combiner.
// Assumes binding to rtsc_top; one clock, sync reset.
`timescale 1ns/100ps

module rtsc_assertions (
    // Clock and reset
    input wire logic        CLK_I,
    input wire logic        SYS_RST_I,
    // Register bus
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    // Recorder side
    input wire logic        STANDBY_I,
    input wire logic        POSTPROC_I,
    input wire logic        TRIG_O,
    input wire logic        ACQ_STOP_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    logic fired_ff;
    wire  bad_addr = (PADDR_I > 8'h20) || (PADDR_I[1:0] != 2'h0);

    // Set by a trigger, cleared when standby drops
    always @(posedge CLK_I)
    begin
        if (SYS_RST_I || !STANDBY_I)
            fired_ff <= 1'b0;
        else if (TRIG_O)
            fired_ff <= 1'b1;
    end

    sequence s_access;
        PSEL_I && PENABLE_I;
    endsequence

    a_ready_access: assert property (s_access |-> PREADY_O)
        else $error("no ready in access phase");
    a_err_unmapped: assert property (s_access ##0 bad_addr |-> PSLVERR_O)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (s_access ##0 !bad_addr |-> !PSLVERR_O)
        else $error("mapped access refused");
    a_err_idle: assert property (!(PSEL_I && PENABLE_I) |-> !PSLVERR_O)
        else $error("error outside access phase");
    a_rd_unmapped: assert property
        (s_access ##0 (bad_addr && !PWRITE_I) |-> PRDATA_O == 32'h0)
        else $error("unmapped read not zero");
    a_trig_pulse: assert property (TRIG_O |=> !TRIG_O)
        else $error("trigger wider than one cycle");
    a_trig_standby: assert property
        (TRIG_O |-> $past(STANDBY_I) && !$past(POSTPROC_I))
        else $error("trigger outside standby");
    a_trig_once: assert property (TRIG_O |-> !fired_ff)
        else $error("second trigger in one standby");
    a_stop_pulse: assert property (ACQ_STOP_O |=> !ACQ_STOP_O)
        else $error("stop wider than one cycle");
endmodule // rtsc_assertions

bind rtsc_top rtsc_assertions rtsc_assertions_inst (
    .CLK_I, .SYS_RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
    .PRDATA_O, .PREADY_O, .PSLVERR_O, .STANDBY_I, .POSTPROC_I,
    .TRIG_O, .ACQ_STOP_O);

/* testbench/rtsc_partner.sv */
// Model of measured signals, outside trigger source and clock.
// Assumes the bench steers levels; shares the block clock.
`timescale 1ns/100ps

module rtsc_partner (
    // Clock
    input  wire logic        clk_i,
    // Steering
    input  wire logic [15:0] rms_set_i,
    input  wire logic [3:0]  pins_set_i,
    input  wire logic        short_i,
    input  wire logic        rtc_run_i,
    // Toward the block
    output logic      [15:0] rms_o,
    output logic      [3:0]  logic_o,
    output wire logic        ext_n_o,
    output logic      [31:0] rtc_o
);
    logic [3:0] div_ff;

    // Released pin returns to its pull-up
    assign ext_n_o = short_i ? 1'b0 : 1'b1;

    always @(posedge clk_i)
    begin
        rms_o   <= rms_set_i;
        logic_o <= pins_set_i;
        div_ff  <= rtc_run_i ? div_ff + 4'h1 : 4'h0;
        if (!rtc_run_i)
            rtc_o <= 32'h0;
        else if (div_ff == 4'hF)
            rtc_o <= rtc_o + 32'h1;
    end
endmodule // rtsc_partner

/* testbench/testbench.sv */
// Self-checking bench for the trigger combiner.
// Assumes rtsc_top with a short chart filter and the partner model.
`timescale 1ns/100ps

module testbench;
    logic        clk = 1'b0;
    logic        rst;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [15:0] rms_set = 16'h0;
    logic [15:0] lvl;
    logic [3:0]  pins = 4'h0;
    logic        ext_short = 1'b0;
    logic        rtc_run = 1'b0;
    logic        start;
    logic        stby_en = 1'b0;
    logic        stby_ok = 1'b1;
    logic        continuous_chart_function;
    logic        post;
    logic [31:0] prdata, rtc;
    logic [15:0] rms;
    logic [3:0]  lg;
    logic [1:0]  rms_ch, mains;
    logic        pready, pslverr, extn, trig, acq;
    logic [31:0] rd_q[$];
    logic        trig_q[$];
    logic        acq_q[$];
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          i;

    always #25 clk = ~clk;

    rtsc_top #(.FILT_CHART_CYC(20)) rtsc_top_inst (
        .CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .RMS_VALUE_I(rms), .RMS_CH_O(rms_ch), .MAINS_SEL_O(mains),
        .LOGIC_I(lg), .OUTSIDE_TRIGGER_INPUT_N_I(extn), .RTC_SEC_I(rtc),
        .MEAS_START_I(start), .STANDBY_I(stby_en & stby_ok),
        .RECORDING_I(continuous_chart_function), .POSTPROC_I(post), .TRIG_O(trig),
        .ACQ_STOP_O(acq));

    rtsc_partner rtsc_partner_inst (
        .clk_i(clk), .rms_set_i(rms_set), .pins_set_i(pins),
        .short_i(ext_short), .rtc_run_i(rtc_run), .rms_o(rms),
        .logic_o(lg), .ext_n_o(extn), .rtc_o(rtc));

    task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask

    task finish_test;
    begin
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask

    task ticks(input int n);
        repeat (n) @(posedge clk);
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
        if (!w)
            rd_q.push_back(d);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= w ? d : 32'h0;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    end
    endtask

    task meas_start;
    begin
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
    end
    endtask

    // Every expected trigger must have arrived by now
    task settle(input int n);
    begin
        ticks(n);
        check(trig_q.size(), 0);
    end
    endtask

    // Result watcher, standby re-entry and hang guard
    always @(posedge clk)
    begin
        if (psel && pen && pready && !pwr)
            check(prdata, rd_q.pop_front());
        if (trig === 1'b1)
            check(trig, trig_q.size() ? trig_q.pop_front() : 1'b0);
        if (acq === 1'b1)
            check(acq, acq_q.size() ? acq_q.pop_front() : 1'b0);
        stby_ok <= (trig !== 1'b1);
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    initial
    begin
        rst <= 1'b1;
        {psel, pen, pwr, start, continuous_chart_function, post} <= 6'h00;
        paddr  <= 8'h00;
        pwdata <= 32'h0;
        i = $urandom(43);
        ticks(5);
        rst <= 1'b0;
        apb(0, 8'h00, 32'h0);
        apb(0, 8'h0C, 32'h1);
        apb(0, 8'h10, 32'h1);
        apb(0, 8'h24, 32'h0);
        apb(0, 8'h06, 32'h0);
        apb(1, 8'h0C, 32'h0);
        apb(0, 8'h0C, 32'h1);
        apb(1, 8'h0C, 32'hC8);
        apb(0, 8'h0C, 32'h64);
        apb(1, 8'h00, 32'h100);
        apb(1, 8'h00, 32'h101);
        apb(0, 8'h00, 32'h001);
        for (i = 0; i < 3; i++)
        begin
            apb(1, 8'h00, (i << 3) | (i << 5));
            ticks(2);
            check({30'h0, mains}, i);
            check({30'h0, rms_ch}, i);
        end
        stby_en <= 1'b1;
        for (i = 0; i < 3; i++)
        begin
            apb(1, 8'h00, (i == 2) ? 32'h0 : 32'h200);
            post <= (i == 1);
            if (i == 0)
                trig_q.push_back(1'b1);
            ext_short <= 1'b1;
            ticks(20);
            ext_short <= 1'b0;
            post <= 1'b0;
            settle(20);
        end
        lvl = 16'($urandom_range(16'hF000, 16'h1000));
        apb(1, 8'h04, {16'h0, lvl});
        for (i = 0; i < 2; i++)
        begin
            apb(1, 8'h00, 32'h2 | (i << 2));
            rms_set <= i ? lvl + 16'h5 : lvl - 16'h5;
            ticks(3);
            meas_start;
            ticks(10);
            trig_q.push_back(1'b1);
            rms_set <= i ? lvl - 16'h5 : lvl + 16'h5;
            ticks(10);
            rms_set <= i ? lvl + 16'h5 : lvl - 16'h5;
            settle(20);
        end
        rms_set <= lvl + 16'h5;
        stby_en <= 1'b0;
        apb(1, 8'h00, 32'h3);
        trig_q.push_back(1'b1);
        stby_en <= 1'b1;
        meas_start;
        stby_en <= 1'b0;
        rms_set <= 16'h0;
        settle(20);
        apb(1, 8'h00, 32'h0);
        apb(1, 8'h08, 32'h6);
        for (i = 0; i < 2; i++)
        begin
            // Standby held off while the pattern is set up
            stby_en <= 1'b0;
            pins <= {2'($urandom), 2'h1};
            apb(1, 8'h00, (i + 1) << 7);
            ticks(10);
            meas_start;
            stby_en <= 1'b1;
            ticks(20);
            trig_q.push_back(1'b1);
            pins <= 4'h2;
            ticks(10);
            pins <= {2'($urandom), 2'h1};
            settle(20);
            pins <= 4'h2;
            ticks(10);
            if (i == 1)
                trig_q.push_back(1'b1);
            pins <= 4'h0;
            settle(20);
        end
        pins <= 4'h2;
        apb(1, 8'h00, 32'h6080);
        meas_start;
        pins <= 4'h1;
        ticks(10);
        pins <= 4'h2;
        ticks(10);
        trig_q.push_back(1'b1);
        pins <= 4'h1;
        settle(40);
        apb(1, 8'h14, 32'h3);
        apb(1, 8'h18, 32'h8);
        apb(1, 8'h1C, 32'h2);
        apb(1, 8'h00, 32'h2400);
        repeat (3) trig_q.push_back(1'b1);
        acq_q.push_back(1'b1);
        rtc_run <= 1'b1;
        meas_start;
        settle(200);
        check(acq_q.size(), 0);
        rtc_run <= 1'b0;
        apb(1, 8'h00, 32'h2C00);
        trig_q.push_back(1'b1);
        rtc_run <= 1'b1;
        meas_start;
        settle(200);
        // AND with timer and outside source, capture function
        rtc_run <= 1'b0;
        ext_short <= 1'b1;
        apb(1, 8'h00, 32'h601);
        repeat (2) trig_q.push_back(1'b1);
        rtc_run <= 1'b1;
        meas_start;
        while (rtc != 32'h4)
            @(posedge clk);
        continuous_chart_function <= 1'b1;
        while (rtc != 32'h6)
            @(posedge clk);
        continuous_chart_function <= 1'b0;
        while (rtc != 32'h7)
            @(posedge clk);
        ticks(8);
        continuous_chart_function <= 1'b1;
        while (rtc != 32'h9)
            @(posedge clk);
        settle(4);
        acq_q.push_back(1'b1);
        continuous_chart_function <= 1'b0;
        ticks(4);
        check(acq_q.size(), 0);
        // Zero interval: only inside the start..end window
        rtc_run <= 1'b0;
        stby_en <= 1'b0;
        apb(1, 8'h1C, 32'h0);
        rtc_run <= 1'b1;
        meas_start;
        for (i = 0; i < 2; i++)
        begin
            while (rtc != 32'h2 + 32'h3 * i)
                @(posedge clk);
            if (i == 1)
                trig_q.push_back(1'b1);
            stby_en <= 1'b1;
            ticks(2);
            stby_en <= 1'b0;
            settle(4);
        end
        finish_test();
    end
endmodule // testbench
